// file: sac_pkg.sv
// Package for the converter control block: register map, fields, codes.
// Assumes a single 10 MHz system clock and a plain register port.
package sac_pkg;
    // Register offsets (byte-wide registers, plain port)
    localparam logic [3:0] OFS_CTRL0 = 4'h0;
    localparam logic [3:0] OFS_CTRL1 = 4'h1;
    localparam logic [3:0] OFS_RES_HI = 4'h2;
    localparam logic [3:0] OFS_RES_LO = 4'h3;
    localparam logic [3:0] OFS_ABE = 4'h4;
    localparam logic [3:0] OFS_STATUS = 4'h5;
    localparam logic [3:0] OFS_MASK = 4'h6;
    // Control 0 fields
    localparam int ENA_BIT = 0;
    localparam int GO_BIT = 1;
    localparam int CHS_LSB = 2;
    localparam int CHS_W = 5;
    // Control 1 field
    localparam int CLKS_LSB = 4;
    localparam int CLKS_W = 3;
    // Block enable field
    localparam int TMPEN_BIT = 0;
    // Status and mask bit
    localparam int DONE_BIT = 0;
    // Clock select codes
    localparam logic [2:0] CLK_DIV8 = 3'h1;
    localparam logic [2:0] CLK_DIV16 = 3'h5;
    localparam logic [2:0] CLK_DIV32 = 3'h2;
    localparam logic [2:0] CLK_DIV64 = 3'h6;
    localparam logic [1:0] CLK_RC_LOW = 2'h3;
    // Divisors in system clocks; RC_DIV counts RC oscillator pulses
    localparam int DIV8 = 8;
    localparam int DIV16 = 16;
    localparam int DIV32 = 32;
    localparam int DIV64 = 64;
    localparam int RC_DIV = 16;
    // Channel codes
    localparam logic [4:0] CH_TEMP = 5'h0A;
    localparam logic [4:0] CH_INT_LAST = 5'h0C;
    localparam logic [4:0] CH_EXT_FIRST = 5'h10;
    // Conversion timing
    localparam int CONV_PERIODS = 11;
    localparam int ABORT_PERIODS = 2;
    localparam int START_DELAY_CYC = 1;
    localparam int RES_W = 10;
    // Reset values
    localparam logic [7:0] CTRL0_RST = 8'h00;
    localparam logic [7:0] CTRL1_RST = 8'h00;
    typedef enum logic [2:0] {
        SAC_IDLE, SAC_DELAY, SAC_CONV, SAC_ABORT
    } sac_state_t;
endpackage

// file: sac_conv_ctrl.sv
// Converter control: channel select, conversion clock, SAR sequence,
// result pair, done flag with mask and wake.
// Assumes the comparator output is synchronous to mclk and settled
// one bit period after each trial code is driven.
// Assumes the RC oscillator arrives as one-cycle enable pulses.
// Assumes sleep_mode is a synchronous level from the power manager.
// Register writes take effect on the edge after the strobe.
//
// Summary of operation
// - Ten-bit successive approximation result, stored right-justified.
// - Completion raises an interrupt that also wakes the device from sleep.
// - Five-bit channel field routes one input to the sample-and-hold.
// - Three-bit clock field picks divide by 8, 16, 32, 64 or RC.
// - RC option is internal oscillator divided by 16.
// - One conversion takes eleven bit periods: one to sample, then one bit each.
// - Non-RC bit periods scale directly with the system clock.
// - Channel code 10 routes the die temperature output.
// - One enable bit powers the sensor and overtemperature shutdown.
// - Start bit begins conversion; done clears it, sets flag, loads result.
// - Clearing start mid-conversion keeps result, waits two periods, then acquires; during the start delay it returns to acquire at once.
// - RC clock delays start; other clocks abort on sleep, power off.
// - Codes 0-12 internal, 10 temperature, 16-23 external, others unused.
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/1ps
module sac_conv_ctrl
    import sac_pkg::*;
#(
    parameter int INSTR_CYC = 4
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Internal RC oscillator enable pulse and sleep state
    input wire logic rc_osc_tick,
    input wire logic sleep_mode,
    // Analog front end
    input wire logic cmp_out,
    output logic [4:0] mux_sel,
    output logic mux_internal,
    output logic [RES_W-1:0] dac_code,
    output logic sample_hold,
    output logic analog_on,
    output logic temp_sensor_enable,
    output logic overtemp_enable,
    // Interrupt and wake
    output logic irq,
    output logic wake
);
    // Start delay counter is eight bits wide
    if (INSTR_CYC < 1 || INSTR_CYC > 255) begin : g_bad_instr
        $error("INSTR_CYC out of range");
    end

    // Reset synchroniser
    logic [1:0] rst_sync_q;
    logic rst_n;
    // Software-visible registers
    logic [7:0] ctrl0_q, ctrl1_q;
    logic tmpen_q;
    logic done_q, mask_q;
    // Successive approximation state
    logic [RES_W-1:0] result_q, sar_q, trial_q;
    logic [3:0] bit_cnt_q;
    sac_state_t state_q;
    // Bit period and start delay counters
    logic [6:0] div_cnt_q;
    logic [4:0] rc_cnt_q;
    logic [7:0] dly_cnt_q;
    // Output registers
    logic [7:0] rdata_q;
    logic irq_q, wake_q;
    logic [4:0] mux_q;
    logic mux_int_q, sh_q, on_q;
    logic [RES_W-1:0] dac_q;

    // Reset release through two flops
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // Field decode
    wire conv_en = ctrl0_q[ENA_BIT];
    wire go_bit = ctrl0_q[GO_BIT];
    wire [4:0] chs = ctrl0_q[CHS_LSB +: CHS_W];
    wire [2:0] clks = ctrl1_q[CLKS_LSB +: CLKS_W];
    wire use_rc = (clks[1:0] == CLK_RC_LOW);
    wire [6:0] div_last = (clks == CLK_DIV8) ? 7'(DIV8 - 1) :
                          (clks == CLK_DIV16) ? 7'(DIV16 - 1) :
                          (clks == CLK_DIV32) ? 7'(DIV32 - 1) :
                          7'(DIV64 - 1);
    wire busy = (state_q == SAC_DELAY) || (state_q == SAC_CONV);
    // Address selects shared by read and write decode
    wire sel_ctrl0 = (reg_addr == OFS_CTRL0);
    wire sel_ctrl1 = (reg_addr == OFS_CTRL1);
    wire sel_res_hi = (reg_addr == OFS_RES_HI);
    wire sel_res_lo = (reg_addr == OFS_RES_LO);
    wire sel_abe = (reg_addr == OFS_ABE);
    wire sel_stat = (reg_addr == OFS_STATUS);
    wire sel_mask = (reg_addr == OFS_MASK);
    // Register port decode
    wire wr_ctrl0 = reg_wr && sel_ctrl0;
    wire wr_ctrl1 = reg_wr && sel_ctrl1;
    wire wr_abe = reg_wr && sel_abe;
    wire wr_stat = reg_wr && sel_stat;
    wire wr_mask = reg_wr && sel_mask;
    // Start only from idle with the converter already on, so a start
    // during the abort wait cannot leave the start bit stuck high
    wire go_set = wr_ctrl0 && reg_wdata[GO_BIT] && !go_bit
                  && reg_wdata[ENA_BIT] && conv_en
                  && (state_q == SAC_IDLE);
    wire go_clr = wr_ctrl0 && !reg_wdata[GO_BIT] && go_bit;
    wire sleep_abort = sleep_mode && !use_rc && busy;
    wire mux_valid = (chs <= CH_INT_LAST) || (chs >= CH_EXT_FIRST &&
                      chs <= 5'h17);

    // Bit period enable: system divider or RC divided by 16
    wire sys_tick = (div_cnt_q == div_last);
    wire rc_tick = rc_osc_tick && (rc_cnt_q == 5'(RC_DIV - 1));
    wire tad_tick = use_rc ? rc_tick : sys_tick;
    wire conv_end = (state_q == SAC_CONV) && tad_tick
                    && (bit_cnt_q == 4'(CONV_PERIODS - 1));
    // Final trial decision folded into the stored result
    wire [RES_W-1:0] conv_result = cmp_out ? (sar_q | trial_q) : sar_q;

    // Divider counters free-running inside a conversion
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_q <= 7'h00;
            rc_cnt_q <= 5'h00;
        end else begin
            if (state_q == SAC_IDLE || sys_tick) begin
                div_cnt_q <= 7'h00;
            end else begin
                div_cnt_q <= div_cnt_q + 7'h01;
            end
            // Wrap at each bit period so RC periods stay sixteen pulses
            if (state_q == SAC_IDLE || rc_tick) begin
                rc_cnt_q <= 5'h00;
            end else if (rc_osc_tick) begin
                rc_cnt_q <= rc_cnt_q + 5'h01;
            end
        end
    end

    // Control registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl0_q <= CTRL0_RST;
            ctrl1_q <= CTRL1_RST;
            tmpen_q <= 1'b0;
            mask_q <= 1'b0;
        end else begin
            // Channel, start and enable; bit 7 always reads zero
            if (wr_ctrl0) begin
                ctrl0_q <= {1'b0, reg_wdata[6:2], go_set, reg_wdata[0]};
            end else if (conv_end || !conv_en || sleep_abort) begin
                // Any end of conversion, an aborted one too, drops start
                ctrl0_q[GO_BIT] <= 1'b0;
            end
            // Clock field only
            if (wr_ctrl1) begin
                ctrl1_q <= {1'b0, reg_wdata[6:4], 4'h0};
            end
            if (wr_abe) begin
                tmpen_q <= reg_wdata[TMPEN_BIT];
            end
            if (wr_mask) begin
                mask_q <= reg_wdata[DONE_BIT];
            end
        end
    end

    // Done flag: set wins over write-one-to-clear
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            done_q <= 1'b0;
        end else if (conv_end) begin
            done_q <= 1'b1;
        end else if (wr_stat && reg_wdata[DONE_BIT]) begin
            done_q <= 1'b0;
        end
    end

    // Conversion sequencer
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= SAC_IDLE;
            bit_cnt_q <= 4'h0;
            dly_cnt_q <= 8'h00;
            sar_q <= '0;
            trial_q <= '0;
            result_q <= '0;
        end else begin
            unique case (state_q)
                // Acquire and wait for a start request
                SAC_IDLE: begin
                    bit_cnt_q <= 4'h0;
                    if (go_set) begin
                        sar_q <= '0;
                        trial_q <= RES_W'(1) << (RES_W - 1);
                        dly_cnt_q <= use_rc ? 8'(INSTR_CYC) :
                                     8'(START_DELAY_CYC);
                        state_q <= SAC_DELAY;
                    end
                end
                // Start delay, longer with the RC clock
                SAC_DELAY: begin
                    if (go_clr || sleep_abort || !conv_en) begin
                        state_q <= SAC_IDLE;
                    end else if (dly_cnt_q <= 8'h01) begin
                        state_q <= SAC_CONV;
                    end else begin
                        dly_cnt_q <= dly_cnt_q - 8'h01;
                    end
                end
                // One sample period, then one bit per period
                SAC_CONV: begin
                    if (go_clr) begin
                        bit_cnt_q <= 4'h0;
                        state_q <= SAC_ABORT;
                    end else if (sleep_abort || !conv_en) begin
                        state_q <= SAC_IDLE;
                    end else if (tad_tick) begin
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                        // First period samples, then one bit each
                        if (bit_cnt_q != 4'h0) begin
                            if (cmp_out) begin
                                sar_q <= sar_q | trial_q;
                            end
                            trial_q <= trial_q >> 1;
                        end
                        if (conv_end) begin
                            result_q <= conv_result;
                            state_q <= SAC_IDLE;
                        end
                    end
                end
                // Two-period wait after a software abort
                SAC_ABORT: begin
                    if (tad_tick) begin
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                        if (bit_cnt_q == 4'(ABORT_PERIODS - 1)) begin
                            state_q <= SAC_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Read data mux, one cycle later; unmapped offsets read zero
    wire [7:0] rd_mux =
        sel_ctrl0 ? ctrl0_q :
        sel_ctrl1 ? ctrl1_q :
        sel_res_hi ? {6'h00, result_q[9:8]} :
        sel_res_lo ? result_q[7:0] :
        sel_abe ? {7'h00, tmpen_q} :
        sel_stat ? {7'h00, done_q} :
        sel_mask ? {7'h00, mask_q} : 8'h00;
    wire [7:0] rdata_d = reg_rd ? rd_mux : 8'h00;

    // Interrupt level and sleep wake request
    wire irq_d = done_q && mask_q;
    wire wake_d = irq_d && sleep_mode;

    // Channel routing: unimplemented codes park the mux on code 0
    wire [4:0] mux_d = mux_valid ? chs : 5'h00;
    wire mux_int_d = mux_valid && (chs <= CH_INT_LAST);

    // Front end drive: sample while acquiring, trial code while converting
    wire sh_d = conv_en && !(state_q == SAC_CONV && bit_cnt_q != 4'h0);
    wire on_d = conv_en && !(sleep_mode && !use_rc) &&
                !(sleep_mode && !mask_q && state_q == SAC_IDLE);

    // Read data register, zero outside the answer cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // Interrupt and wake registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
            wake_q <= wake_d;
        end
    end

    // Front end registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mux_q <= 5'h00;
            mux_int_q <= 1'b0;
            dac_q <= '0;
            sh_q <= 1'b0;
            on_q <= 1'b0;
        end else begin
            mux_q <= mux_d;
            mux_int_q <= mux_int_d;
            dac_q <= sar_q | trial_q;
            sh_q <= sh_d;
            on_q <= on_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign irq = irq_q;
    assign wake = wake_q;
    assign mux_sel = mux_q;
    assign mux_internal = mux_int_q;
    assign dac_code = dac_q;
    assign sample_hold = sh_q;
    assign analog_on = on_q;
    assign temp_sensor_enable = tmpen_q;
    assign overtemp_enable = tmpen_q;
endmodule

// file: sac_conv_ctrl_chk.sv
// Checker for the converter control block, bound to its top ports.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/1ps
module sac_conv_ctrl_chk
    import sac_pkg::*;
(
    // Clock and reset
    input logic mclk,
    input logic arst_n,
    // Register port
    input logic [3:0] reg_addr,
    input logic [7:0] reg_wdata,
    input logic reg_wr,
    input logic reg_rd,
    input logic [7:0] reg_rdata,
    // Oscillator, sleep, analog side
    input logic rc_osc_tick,
    input logic sleep_mode,
    input logic cmp_out,
    input logic [4:0] mux_sel,
    input logic mux_internal,
    input logic [RES_W-1:0] dac_code,
    input logic sample_hold,
    input logic analog_on,
    input logic temp_sensor_enable,
    input logic overtemp_enable,
    // Interrupt and wake
    input logic irq,
    input logic wake
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    // Read strobe at one offset, answer in the following cycle
    sequence rd_at(logic [3:0] a);
        reg_rd && reg_addr == a ##1 1'b1;
    endsequence

    res_hi_pad_a: assert property (
        rd_at(OFS_RES_HI) |-> reg_rdata[7:2] == 6'h00)
        else $error("result high byte has bits above bit 1");
    wake_in_sleep_a: assert property (
        wake |-> $past(sleep_mode))
        else $error("wake raised outside sleep");
    wake_needs_irq_a: assert property (
        wake |-> irq || $past(irq))
        else $error("wake without a pending interrupt");
    chan_internal_a: assert property (
        mux_internal |-> mux_sel <= CH_INT_LAST)
        else $error("internal flag on an external channel");
    chan_unimpl_a: assert property (
        !(mux_sel inside {[5'h0D:5'h0F], [5'h18:5'h1F]}))
        else $error("unimplemented channel code routed");
    temp_pair_a: assert property (
        temp_sensor_enable == overtemp_enable)
        else $error("sensor and shutdown enables differ");
    clk_field_a: assert property (
        rd_at(OFS_CTRL1) |-> reg_rdata[7] == 1'b0 && reg_rdata[3:0] == 4'h0)
        else $error("clock control reads bits outside its field");
    go_needs_en_a: assert property (
        rd_at(OFS_CTRL0) |-> !(reg_rdata[GO_BIT] && !reg_rdata[ENA_BIT]))
        else $error("start bit reads set while converter disabled");
endmodule

bind sac_conv_ctrl sac_conv_ctrl_chk u_chk (
    .mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rc_osc_tick(rc_osc_tick),
    .sleep_mode(sleep_mode), .cmp_out(cmp_out), .mux_sel(mux_sel),
    .mux_internal(mux_internal), .dac_code(dac_code),
    .sample_hold(sample_hold), .analog_on(analog_on),
    .temp_sensor_enable(temp_sensor_enable),
    .overtemp_enable(overtemp_enable), .irq(irq), .wake(wake)
);

// file: sac_conv_ctrl_bench.sv
// Self-checking bench for the converter control block.
// Drives all ports itself; comparator follows a fixed input level.
`timescale 1ns/1ps
module sac_conv_ctrl_bench;
    import sac_pkg::*;
    localparam int INSTR = 4;
    logic mclk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    logic rc_osc_tick = 0, sleep_mode = 0, cmp_out = 0;
    logic [4:0] mux_sel;
    logic [RES_W-1:0] dac_code, vin = 10'h000;
    logic mux_internal, sample_hold, analog_on, irq, wake;
    logic temp_sensor_enable, overtemp_enable;
    int err_total = 0, n_compared = 0;
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_total++; \
    $display("mismatch t=%0t got %h exp %h", $time, a, e); end end

    sac_conv_ctrl #(.INSTR_CYC(INSTR)) u_dut (
        .mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .rc_osc_tick(rc_osc_tick),
        .sleep_mode(sleep_mode), .cmp_out(cmp_out), .mux_sel(mux_sel),
        .mux_internal(mux_internal), .dac_code(dac_code),
        .sample_hold(sample_hold), .analog_on(analog_on),
        .temp_sensor_enable(temp_sensor_enable),
        .overtemp_enable(overtemp_enable), .irq(irq), .wake(wake)
    );

    // 10 MHz system clock
    initial begin
        forever #50 mclk = ~mclk;
    end
    // RC oscillator pulses and comparator with a half-step offset
    always @(posedge mclk) begin
        rc_osc_tick <= ~rc_osc_tick;
        cmp_out <= {vin, 1'b1} > {dac_code, 1'b0};
    end

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic settle;
        repeat (2) @(posedge mclk);
        #1;
    endtask
    task automatic wait_irq(output int n);
        n = 0;
        while (irq !== 1'b1 && n < 3000) begin
            @(posedge mclk);
            n++;
        end
    endtask
    // Full conversion: timing window, result pair, start bit cleared
    task automatic conv(input logic [2:0] cs, input logic [9:0] v,
                        input int per, input int ex);
        int n;
        logic [7:0] d;
        vin = v;
        wr(OFS_CTRL1, {1'b0, cs, 4'h0});
        wr(OFS_CTRL0, 8'h01);
        repeat (4) @(posedge mclk);
        wr(OFS_CTRL0, 8'h03);
        wait_irq(n);
        `CHK(n >= 10 * per && n <= 11 * per + ex + 4, 1'b1)
        `CHK(dac_code, v)
        rd(OFS_RES_HI, d);
        `CHK(d, {6'h00, v[9:8]})
        rd(OFS_RES_LO, d);
        `CHK(d, v[7:0])
        rd(OFS_CTRL0, d);
        `CHK(d, 8'h01)
        wr(OFS_STATUS, 8'h01);
    endtask
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        repeat (20000) @(posedge mclk);
        err_total++;
        stop_test;
    end

    // Main sequence
    initial begin
        logic [7:0] d;
        int n;
        repeat (3) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        wr(OFS_MASK, 8'h01);
        conv(CLK_DIV8, 10'h2A5, DIV8, 0);
        conv(CLK_DIV16, 10'h3FF, DIV16, 0);
        conv(CLK_DIV32, 10'h000, DIV32, 0);
        conv(CLK_DIV64, 10'h155, DIV64, 0);
        conv(3'h3, 10'h200, 2 * RC_DIV, INSTR);
        conv(3'h7, 10'h1FF, 2 * RC_DIV, INSTR);
        settle;
        `CHK(irq, 1'b0)
        // Masked completion keeps the sticky flag, unmask raises line
        wr(OFS_MASK, 8'h00);
        wr(OFS_CTRL0, 8'h03);
        repeat (500) @(posedge mclk);
        `CHK(irq, 1'b0)
        rd(OFS_STATUS, d);
        `CHK(d, 8'h01)
        wr(OFS_MASK, 8'h01);
        settle;
        `CHK(irq, 1'b1)
        wr(OFS_STATUS, 8'h01);
        settle;
        `CHK(irq, 1'b0)
        // Start while disabled is ignored
        wr(OFS_CTRL0, 8'h00);
        wr(OFS_CTRL0, 8'h02);
        repeat (20) @(posedge mclk);
        rd(OFS_CTRL0, d);
        `CHK(d, 8'h00)
        // Channel routing: temperature, first pin, unimplemented
        wr(OFS_CTRL0, {1'b0, CH_TEMP, 2'b01});
        settle;
        `CHK(mux_sel, CH_TEMP)
        `CHK(mux_internal, 1'b1)
        `CHK(sample_hold, 1'b1)
        wr(OFS_CTRL0, {1'b0, CH_EXT_FIRST, 2'b01});
        settle;
        `CHK(mux_sel, CH_EXT_FIRST)
        `CHK(mux_internal, 1'b0)
        wr(OFS_CTRL0, 8'h35);
        settle;
        `CHK(mux_sel, 5'h00)
        wr(OFS_ABE, 8'h01);
        settle;
        `CHK(temp_sensor_enable, 1'b1)
        `CHK(overtemp_enable, 1'b1)
        rd(4'h9, d);
        `CHK(d, 8'h00)
        // Abort mid conversion keeps the old result
        vin = 10'h0F0;
        wr(OFS_CTRL0, 8'h01);
        wr(OFS_CTRL1, 8'h50);
        wr(OFS_CTRL0, 8'h03);
        repeat (60) @(posedge mclk);
        wr(OFS_CTRL0, 8'h01);
        repeat (100) @(posedge mclk);
        rd(OFS_RES_LO, d);
        `CHK(d, 8'hFF)
        rd(OFS_STATUS, d);
        `CHK(d, 8'h00)
        // Sleep aborts a system-clock conversion
        `CHK(analog_on, 1'b1)
        wr(OFS_CTRL1, 8'h60);
        wr(OFS_CTRL0, 8'h03);
        repeat (50) @(posedge mclk);
        sleep_mode <= 1'b1;
        settle;
        `CHK(analog_on, 1'b0)
        rd(OFS_CTRL0, d);
        `CHK(d, 8'h01)
        repeat (800) @(posedge mclk);
        `CHK(irq, 1'b0)
        sleep_mode <= 1'b0;
        // RC clock converts through sleep and wakes the device
        vin = 10'h0AA;
        wr(OFS_CTRL1, 8'h30);
        wr(OFS_CTRL0, 8'h03);
        sleep_mode <= 1'b1;
        wait_irq(n);
        `CHK(n < 3000, 1'b1)
        settle;
        `CHK(wake, 1'b1)
        rd(OFS_RES_LO, d);
        `CHK(d, 8'hAA)
        sleep_mode <= 1'b0;
        stop_test;
    end
endmodule
